// [core/agc_params.svh]
`ifndef AGC_PARAMS_SVH
`define AGC_PARAMS_SVH

`define AGC_ADDR_MODE 8'h00
`define AGC_ADDR_FAST 8'h04
`define AGC_ADDR_AUX 8'h08
`define AGC_ADDR_GAIN 8'h0c
`define AGC_ADDR_STAT 8'h10

`define AGC_MODE_LSB 2
`define AGC_MODE_MSB 3
`define AGC_HOLD_BIT 4
`define AGC_RDBK_BIT 7
`define AGC_ATK_LSB 0
`define AGC_REL_LSB 4
`define AGC_SEL_W 3

`define AGC_MODE_MASK 8'h1c
`define AGC_RATE_MASK 8'h77
`define AGC_MODE_RST 8'h00
`define AGC_RATE_RST 8'h00
`define AGC_GAIN_RST 8'h52

`define AGC_RESP_OKAY 2'h0
`define AGC_RESP_SLVERR 2'h2

`define AGC_CLK_KHZ 200000
`define AGC_HOLD_LONG_MS 50
`define AGC_HOLD_SHORT_MS 25
`define AGC_FIX_RATE_DBPS 80000
`define AGC_STEP_MDB 500
`define AGC_STEP_BASE_CYC (`AGC_CLK_KHZ * `AGC_STEP_MDB / `AGC_FIX_RATE_DBPS)

`endif

// [core/agc_pkg.sv]
package agc_pkg;

    typedef enum logic [1:0] {
        AGC_DUAL,
        AGC_SINGLE,
        AGC_FIXSTEP,
        AGC_FIXIMM
    } agc_mode_e;

    typedef logic [6:0] agc_gain_t;

endpackage : agc_pkg

// [core/agc_step_if.sv]
`timescale 1ns/1ps
interface agc_step_if #(parameter int W = 7, parameter int SELW = 3);
    logic [SELW-1:0] dn_sel;
    logic [SELW-1:0] up_sel;
    logic dn_req;
    logic up_req;
    logic load_en;
    logic [W-1:0] load_val;
    logic [W-1:0] value;

    modport ctl (output dn_sel, up_sel, dn_req, up_req, load_en, load_val, input value);
    modport cnt (input dn_sel, up_sel, dn_req, up_req, load_en, load_val, output value);
endinterface : agc_step_if

// [core/agc_step_counter.sv]
`timescale 1ns/1ps
module agc_step_counter #(
    parameter int W = 7,
    parameter int SELW = 3,
    parameter int BASE = 1250
) (
    input wire logic clk_sys_in, // System clock.
    input wire logic rst_in,     // Synchronous reset, active high.
    agc_step_if.cnt step_if      // Step requests and counter value.
);
    localparam int DW = $clog2(BASE << ((1 << SELW) - 1)) + 1;

    logic [DW-1:0] div_q;
    logic [DW-1:0] period;
    logic [SELW-1:0] sel;
    logic [W-1:0] value_q;

    // The tick period is the base step time scaled by a power of two.
    always_comb begin
        sel = step_if.dn_req ? step_if.dn_sel : step_if.up_sel;
        period = DW'(BASE) << sel;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            div_q <= '0;
            value_q <= '0;
        end else if (step_if.load_en) begin
            div_q <= '0;
            value_q <= step_if.load_val;
        end else if (step_if.dn_req || step_if.up_req) begin
            if (div_q >= period - DW'(1)) begin
                div_q <= '0;
                if (step_if.dn_req && value_q != '0) begin
                    value_q <= value_q - W'(1);
                end else if (!step_if.dn_req && value_q != '1) begin
                    value_q <= value_q + W'(1);
                end
            end else begin
                div_q <= div_q + DW'(1);
            end
        end else begin
            div_q <= '0;
        end
    end

    assign step_if.value = value_q;

endmodule : agc_step_counter

// [core/agc_gain_controller.sv]
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "agc_params.svh"
module agc_gain_controller #(
    parameter int HOLD_LONG_CYC = `AGC_HOLD_LONG_MS * `AGC_CLK_KHZ,
    parameter int HOLD_SHORT_CYC = `AGC_HOLD_SHORT_MS * `AGC_CLK_KHZ,
    parameter int STEP_BASE_CYC = `AGC_STEP_BASE_CYC
) (
    input wire logic clk_sys_in,        // System clock.
    input wire logic rst_in,            // Synchronous reset, active high.
    input wire logic [31:0] awaddr_in,  // Write address.
    input wire logic awvalid_in,        // Write address valid.
    output logic awready_out,           // Write address ready.
    input wire logic [31:0] wdata_in,   // Write data.
    input wire logic [3:0] wstrb_in,    // Write byte strobes.
    input wire logic wvalid_in,         // Write data valid.
    output logic wready_out,            // Write data ready.
    output logic [1:0] bresp_out,       // Write response.
    output logic bvalid_out,            // Write response valid.
    input wire logic bready_in,         // Write response ready.
    input wire logic [31:0] araddr_in,  // Read address.
    input wire logic arvalid_in,        // Read address valid.
    output logic arready_out,           // Read address ready.
    output logic [31:0] rdata_out,      // Read data.
    output logic [1:0] rresp_out,       // Read response.
    output logic rvalid_out,            // Read data valid.
    input wire logic rready_in,         // Read data ready.
    input wire logic above_upper_in,    // Output above the upper peak threshold.
    input wire logic below_lower_in,    // Output below the lower threshold.
    output logic [6:0] gain_code_out    // Applied gain code, 0.5 dB a step.
);
    localparam int HW = $clog2(HOLD_LONG_CYC + 1);

    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [7:0] mode_q;
    logic [7:0] fast_rate_q;
    logic [7:0] aux_rate_q;
    logic [7:0] gain_target_q;
    logic [HW-1:0] hold_cnt_q;
    agc_pkg::agc_gain_t gain_code_q;

    logic wr_fire;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_mux;
    logic hold_done;
    logic [HW-1:0] hold_lim;
    logic auto_mode;
    agc_pkg::agc_mode_e mode;
    agc_pkg::agc_gain_t max_code;
    agc_pkg::agc_gain_t fast_val;
    agc_pkg::agc_gain_t slow_val;
    agc_pkg::agc_gain_t gain_min;

    agc_step_if #(.W(7), .SELW(`AGC_SEL_W)) fast_if ();
    agc_step_if #(.W(7), .SELW(`AGC_SEL_W)) slow_if ();

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    assign mode = agc_pkg::agc_mode_e'(mode_q[`AGC_MODE_MSB:`AGC_MODE_LSB]);
    assign auto_mode = (mode == agc_pkg::AGC_DUAL) || (mode == agc_pkg::AGC_SINGLE);
    assign max_code = gain_target_q[6:0];
    assign fast_val = fast_if.value;
    assign slow_val = slow_if.value;
    assign gain_min = (fast_val < slow_val) ? fast_val : slow_val;

    // Write channel: address and data are latched in either order.
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

    always_comb begin
        case (awaddr_q)
            `AGC_ADDR_MODE, `AGC_ADDR_FAST, `AGC_ADDR_AUX, `AGC_ADDR_GAIN: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `AGC_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
        end else begin
            if (awvalid_in && awready_q) begin
                aw_have_q <= 1'b1;
                awaddr_q <= awaddr_in[7:0];
                awready_q <= 1'b0;
            end
            if (wvalid_in && wready_q) begin
                w_have_q <= 1'b1;
                wdata_q <= wdata_in[7:0];
                wstrb0_q <= wstrb_in[0];
                wready_q <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `AGC_RESP_OKAY : `AGC_RESP_SLVERR;
            end
            if (bvalid_q && bready_in) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Register file; reserved bits are masked so they read as zero.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            mode_q <= `AGC_MODE_RST;
            fast_rate_q <= `AGC_RATE_RST;
            aux_rate_q <= `AGC_RATE_RST;
            gain_target_q <= `AGC_GAIN_RST;
        end else if (wr_fire && wstrb0_q) begin
            case (awaddr_q)
                `AGC_ADDR_MODE: mode_q <= wdata_q & `AGC_MODE_MASK;
                `AGC_ADDR_FAST: fast_rate_q <= wdata_q & `AGC_RATE_MASK;
                `AGC_ADDR_AUX: aux_rate_q <= wdata_q & `AGC_RATE_MASK;
                `AGC_ADDR_GAIN: gain_target_q <= wdata_q;
                default: mode_q <= mode_q;
            endcase
        end
    end

    // Read channel.
    always_comb begin
        rd_hit = 1'b1;
        case (araddr_in[7:0])
            `AGC_ADDR_MODE: rd_mux = {24'h000000, mode_q};
            `AGC_ADDR_FAST: rd_mux = {24'h000000, fast_rate_q};
            `AGC_ADDR_AUX: rd_mux = {24'h000000, aux_rate_q};
            `AGC_ADDR_GAIN: begin
                if (gain_target_q[`AGC_RDBK_BIT]) begin
                    rd_mux = {24'h000000, 1'b1, gain_code_q};
                end else begin
                    rd_mux = {24'h000000, gain_target_q};
                end
            end
            `AGC_ADDR_STAT: begin
                rd_mux = {15'h0000, hold_done, 1'b0, slow_val, 1'b0, fast_val};
            end
            default: begin
                rd_mux = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= `AGC_RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            if (arvalid_in && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_hit ? `AGC_RESP_OKAY : `AGC_RESP_SLVERR;
            end
            if (rvalid_q && rready_in) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // Hold-off timer: restarts whenever the output leaves the quiet band.
    assign hold_lim = mode_q[`AGC_HOLD_BIT] ? HW'(HOLD_SHORT_CYC) : HW'(HOLD_LONG_CYC);
    assign hold_done = (hold_cnt_q >= hold_lim);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            hold_cnt_q <= '0;
        end else if (!below_lower_in) begin
            hold_cnt_q <= '0;
        end else if (!hold_done) begin
            hold_cnt_q <= hold_cnt_q + HW'(1);
        end
    end

    // Fast counter requests.
    always_comb begin
        fast_if.dn_sel = fast_rate_q[`AGC_ATK_LSB +: `AGC_SEL_W];
        fast_if.up_sel = fast_rate_q[`AGC_REL_LSB +: `AGC_SEL_W];
        fast_if.dn_req = 1'b0;
        fast_if.up_req = 1'b0;
        fast_if.load_en = 1'b0;
        fast_if.load_val = max_code;
        case (mode)
            agc_pkg::AGC_DUAL, agc_pkg::AGC_SINGLE: begin
                fast_if.dn_req = (above_upper_in && fast_val != '0) || fast_val > max_code;
                fast_if.up_req = !above_upper_in && below_lower_in && hold_done
                    && fast_val < max_code;
            end
            agc_pkg::AGC_FIXSTEP: begin
                fast_if.dn_req = fast_val > max_code;
                fast_if.up_req = fast_val < max_code;
            end
            agc_pkg::AGC_FIXIMM: begin
                fast_if.load_en = 1'b1;
            end
            default: fast_if.load_en = 1'b0;
        endcase
    end

    // Slow counter follows the fast one; outside dual mode it is parked on it.
    always_comb begin
        slow_if.dn_sel = aux_rate_q[`AGC_ATK_LSB +: `AGC_SEL_W];
        slow_if.up_sel = aux_rate_q[`AGC_REL_LSB +: `AGC_SEL_W];
        slow_if.load_val = fast_val;
        if (mode == agc_pkg::AGC_DUAL) begin
            slow_if.dn_req = slow_val > fast_val;
            slow_if.up_req = slow_val < fast_val;
            slow_if.load_en = 1'b0;
        end else begin
            slow_if.dn_req = 1'b0;
            slow_if.up_req = 1'b0;
            slow_if.load_en = 1'b1;
        end
    end

    agc_step_counter #(.W(7), .SELW(`AGC_SEL_W), .BASE(STEP_BASE_CYC)) u_fast (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .step_if(fast_if.cnt)
    );

    agc_step_counter #(.W(7), .SELW(`AGC_SEL_W), .BASE(STEP_BASE_CYC)) u_slow (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .step_if(slow_if.cnt)
    );

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            gain_code_q <= '0;
        end else if (mode == agc_pkg::AGC_DUAL) begin
            gain_code_q <= gain_min;
        end else begin
            gain_code_q <= fast_val;
        end
    end

    assign awready_out = awready_q;
    assign wready_out = wready_q;
    assign bvalid_out = bvalid_q;
    assign bresp_out = bresp_q;
    assign arready_out = arready_q;
    assign rvalid_out = rvalid_q;
    assign rresp_out = rresp_q;
    assign rdata_out = rdata_q;
    assign gain_code_out = gain_code_q;

    sequence s_gain_rd;
        arvalid_in && arready_q && araddr_in[7:0] == `AGC_ADDR_GAIN
            && gain_target_q[`AGC_RDBK_BIT];
    endsequence

    sequence s_fast_rise;
        fast_val > $past(fast_val);
    endsequence

    sequence s_gain_rd_raw;
        arvalid_in && arready_q && araddr_in[7:0] == `AGC_ADDR_GAIN
            && !gain_target_q[`AGC_RDBK_BIT];
    endsequence

    AST_READBACK: assert property (s_gain_rd |=> rdata_q[6:0] == $past(gain_code_q))
        else $error("Live gain read-back mismatch.");

    AST_DUAL_MIN: assert property (mode == agc_pkg::AGC_DUAL
        |=> gain_code_q <= $past(fast_val) && gain_code_q <= $past(slow_val)
        && (gain_code_q == $past(fast_val) || gain_code_q == $past(slow_val)))
        else $error("Dual mode gain is not the smaller counter.");

    AST_SINGLE: assert property (mode == agc_pkg::AGC_SINGLE |=> gain_code_q == $past(fast_val))
        else $error("Single mode gain does not follow fast counter.");

    AST_IMMEDIATE: assert property (mode == agc_pkg::AGC_FIXIMM |=> fast_val == $past(max_code))
        else $error("Immediate mode did not jump to target.");

    AST_HOLDOFF: assert property (s_fast_rise ##0 $past(auto_mode) |-> $past(hold_done))
        else $error("Gain rose before hold-off elapsed.");

    AST_PEAK_DOWN: assert property ($past(auto_mode) && $past(above_upper_in)
        |-> fast_val <= $past(fast_val))
        else $error("Gain rose while above upper threshold.");

    AST_SAT_MAX: assert property (s_fast_rise ##0 $past(auto_mode)
        |-> fast_val <= $past(max_code))
        else $error("Fast counter rose past the maximum.");

    AST_STEPPED: assert property ($past(mode == agc_pkg::AGC_FIXSTEP)
        && fast_val != $past(fast_val)
        |-> (fast_val == $past(fast_val) + 7'h01 && $past(fast_val) < $past(max_code))
        || (fast_val == $past(fast_val) - 7'h01 && $past(fast_val) > $past(max_code)))
        else $error("Stepped mode moved wrongly.");

    AST_SLOW_TRACK: assert property ($past(mode == agc_pkg::AGC_DUAL)
        && slow_val != $past(slow_val)
        |-> (slow_val == $past(slow_val) + 7'h01 && $past(slow_val) < $past(fast_val))
        || (slow_val == $past(slow_val) - 7'h01 && $past(slow_val) > $past(fast_val)))
        else $error("Slow counter did not step toward fast counter.");

    AST_STORED: assert property (s_gain_rd_raw
        |=> rdata_q[7:0] == $past(gain_target_q))
        else $error("Stored gain read-back mismatch.");

    AST_UP_QUIET: assert property (s_fast_rise ##0 $past(auto_mode)
        |-> $past(below_lower_in) && !$past(above_upper_in))
        else $error("Gain rose while the output was not quiet.");

    AST_SAT_MIN: assert property ($past(fast_val) == 7'h00
        && $past(mode != agc_pkg::AGC_FIXIMM) |-> fast_val <= 7'h01)
        else $error("Fast counter wrapped below code zero.");

    AST_SINGLE_SLOW: assert property ($past(mode == agc_pkg::AGC_SINGLE)
        |-> slow_val == $past(fast_val))
        else $error("Slow counter ran in single-rate mode.");

    AST_FIX_LEVEL: assert property ($past(mode == agc_pkg::AGC_FIXSTEP)
        && $past(fast_val == max_code) |-> fast_val == $past(fast_val))
        else $error("Fixed gain moved with the signal level.");

    AST_PACE: assert property (mode == agc_pkg::AGC_FIXSTEP
        && fast_val != $past(fast_val) |=> fast_val == $past(fast_val))
        else $error("Stepped gain moved on two cycles in a row.");

endmodule : agc_gain_controller

// [test/agc_comp_model.sv]
`timescale 1ns/1ps
module agc_comp_model (
    input wire logic clk_in,          // System clock.
    input wire logic [1:0] level_in,  // Commanded level: 0 quiet, 1 mid, 2 loud.
    output logic above_upper_out,     // Output above the upper peak threshold.
    output logic below_lower_out      // Output below the lower threshold.
);
    logic [1:0] lvl_q = 2'h1;
    initial above_upper_out = 1'b0;
    initial below_lower_out = 1'b0;
    // Two register stages stand in for the comparator and its synchroniser.
    always @(posedge clk_in) begin
        lvl_q <= level_in;
        above_upper_out <= (lvl_q == 2'h2);
        below_lower_out <= (lvl_q == 2'h0);
    end
endmodule : agc_comp_model

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] level = 2'h1;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
    logic above_upper, below_lower;
    logic [1:0] bresp_out, rresp_out;
    logic [31:0] rdata_out;
    logic [6:0] gain_code_out;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;

    always #2.5 clk_sys_in = ~clk_sys_in;

    agc_gain_controller #(.HOLD_LONG_CYC(40), .HOLD_SHORT_CYC(20), .STEP_BASE_CYC(4)) dut_u (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready_out),
        .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid), .wready_out(wready_out),
        .bresp_out(bresp_out), .bvalid_out(bvalid_out), .bready_in(bready),
        .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready_out),
        .rdata_out(rdata_out), .rresp_out(rresp_out), .rvalid_out(rvalid_out),
        .rready_in(rready), .above_upper_in(above_upper), .below_lower_in(below_lower),
        .gain_code_out(gain_code_out));

    agc_comp_model cmp_u (.clk_in(clk_sys_in), .level_in(level),
        .above_upper_out(above_upper), .below_lower_out(below_lower));

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 8000) begin
            err_count++;
            $display("wrong value at %0t: run did not finish", $time);
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic chk_in(input int got, input int lo, input int hi, input string msg);
        checks_done++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("wrong value at %0t: %s took %0d not %0d..%0d", $time, msg, got, lo, hi);
        end
    endtask : chk_in

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            if (awvalid && awready_out === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready_out === 1'b1) wvalid <= 1'b0;
        end while (bvalid_out !== 1'b1);
        chk({30'h0, bresp_out}, {30'h0, er}, "write response");
        bready <= 1'b0;
        @(posedge clk_sys_in);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            if (arvalid && arready_out === 1'b1) arvalid <= 1'b0;
        end while (rvalid_out !== 1'b1);
        chk({30'h0, rresp_out}, {30'h0, er}, "read response");
        if (er == 2'h0) chk(rdata_out, ed, "read data");
        rready <= 1'b0;
        @(posedge clk_sys_in);
    endtask : rdc

    // Follows the gain to a target, checking it never moves by more than one code a cycle.
    task automatic walk(input logic [6:0] tgt, output int n);
        logic [6:0] prev;
        n = 0;
        prev = gain_code_out;
        while (gain_code_out !== tgt) begin
            @(posedge clk_sys_in);
            chk({31'h0, (gain_code_out - prev) == 7'h1 || (prev - gain_code_out) == 7'h1
                || gain_code_out == prev}, 32'h1, "single step");
            prev = gain_code_out;
            n++;
        end
    endtask : walk

    task automatic leave(input logic [6:0] v, output int n);
        n = 0;
        while (gain_code_out === v) begin
            @(posedge clk_sys_in);
            n++;
        end
    endtask : leave

    task automatic t_reset();
        rdc(8'h00, 32'h0, 2'h0);
        rdc(8'h04, 32'h0, 2'h0);
        rdc(8'h08, 32'h0, 2'h0);
        rdc(8'h0c, 32'h52, 2'h0);
        chk({25'h0, gain_code_out}, 32'h0, "gain after reset");
        rdc(8'h14, 32'h0, 2'h2);
        wr(8'h10, 32'h0, 2'h2);
        wr(8'h00, 32'he3, 2'h0);
        rdc(8'h00, 32'h0, 2'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_immediate();
        level <= 2'h2;
        wr(8'h00, 32'h0c, 2'h0);
        wr(8'h0c, 32'h20, 2'h0);
        repeat (3) @(posedge clk_sys_in);
        chk({25'h0, gain_code_out}, 32'h20, "jump up");
        wr(8'h0c, 32'h05, 2'h0);
        repeat (2) @(posedge clk_sys_in);
        chk({25'h0, gain_code_out}, 32'h05, "jump down");
        $display("test immediate done");
    endtask : t_immediate

    task automatic t_stepped();
        int n;
        wr(8'h04, 32'h10, 2'h0);
        wr(8'h00, 32'h08, 2'h0);
        wr(8'h0c, 32'h8d, 2'h0);
        rdc(8'h0c, 32'h85, 2'h0);
        walk(7'h0d, n);
        chk_in(n, 60, 72, "stepped rise");
        rdc(8'h0c, 32'h8d, 2'h0);
        wr(8'h0c, 32'h09, 2'h0);
        walk(7'h09, n);
        chk_in(n, 12, 20, "stepped fall");
        rdc(8'h0c, 32'h09, 2'h0);
        $display("test stepped done");
    endtask : t_stepped

    task automatic t_single();
        int n;
        wr(8'h04, 32'h00, 2'h0);
        wr(8'h0c, 32'h06, 2'h0);
        wr(8'h00, 32'h04, 2'h0);
        walk(7'h00, n);
        chk_in(n, 30, 44, "attack to floor");
        repeat (10) @(posedge clk_sys_in);
        chk({25'h0, gain_code_out}, 32'h0, "floor holds");
        level <= 2'h0;
        leave(7'h00, n);
        chk_in(n, 40, 54, "long hold-off");
        walk(7'h06, n);
        repeat (30) @(posedge clk_sys_in);
        chk({25'h0, gain_code_out}, 32'h06, "ceiling holds");
        level <= 2'h1;
        repeat (20) @(posedge clk_sys_in);
        chk({25'h0, gain_code_out}, 32'h06, "hysteresis band");
        level <= 2'h2;
        walk(7'h00, n);
        $display("test single done");
    endtask : t_single

    task automatic t_short_hold();
        int n;
        wr(8'h00, 32'h14, 2'h0);
        level <= 2'h0;
        leave(7'h00, n);
        chk_in(n, 20, 34, "short hold-off");
        walk(7'h06, n);
        $display("test short hold done");
    endtask : t_short_hold

    task automatic t_dual();
        wr(8'h08, 32'h22, 2'h0);
        wr(8'h00, 32'h00, 2'h0);
        level <= 2'h2;
        repeat (12) @(posedge clk_sys_in);
        level <= 2'h1;
        repeat (4) @(posedge clk_sys_in);
        rdc(8'h10, 32'h00000603, 2'h0);
        chk({25'h0, gain_code_out}, 32'h03, "smaller counter");
        level <= 2'h0;
        repeat (300) @(posedge clk_sys_in);
        rdc(8'h10, 32'h00010606, 2'h0);
        chk({25'h0, gain_code_out}, 32'h06, "dual settles");
        $display("test dual done");
    endtask : t_dual

    initial begin
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        t_reset();
        t_immediate();
        t_stepped();
        t_single();
        t_short_hold();
        t_dual();
        summarize();
    end
endmodule : tb_top
